// >>> pmic_reset_status_pins_test.sv
// Self-checking bench for the pin supervisor
`timescale 1ns/100ps
`default_nettype none
module pmic_reset_status_pins_test;
   localparam int RESTART = 20;
   logic clk = 0, nrst = 0, sd = 0, btn = 1, ext = 0, svc = 0, go = 0, ex, el;
   logic rd, req, ioe, io, woe, wo, ag, lg, en;
   logic [6:0] rok = 7'h7f;
   logic [3:0] msk = 4'h0, st;
   logic [31:0] rs = 32'h0000_0033;
   int err_count = 0, n_checks = 0, cyc = 0, t;
   wire logic irq = ioe ? 1'b1 : io;
   always #2 clk = ~clk;
   prsp_top #(.RESTART_CYC(RESTART)) dut (.clk(clk), .nrst(nrst), .clk_en(1'b1),
      .hard_shutdown_input(sd), .button_monitor_input(btn), .power_up_request(req),
      .rail_ok(rok), .ext_event(ext), .evt_mask(msk), .evt_read(rd), .evt_status(st),
      .irq_request_low_o(io), .irq_request_low_oe_n(ioe), .wake_notify_low_o(wo),
      .wake_notify_low_oe_n(woe), .all_rails_good(ag), .linear_rails_good(lg),
      .rails_enable(en));
   prsp_host_model host (.clk(clk), .nrst(nrst), .service_en(svc), .start(go),
      .irq_line(irq), .evt_read(rd), .power_up_request(req));
   function logic [31:0] xs(input logic [31:0] s);
      xs = s ^ (s << 13);
      xs = xs ^ (xs >> 17);
      xs = xs ^ (xs << 5);
   endfunction : xs
   task chk(input string nm, input logic e, input logic s);
      n_checks++;
      if (s !== e)
      begin
         err_count++;
         $display("mismatch %s expected %b seen %b", nm, e, s);
      end
   endtask : chk
   task complete_run;
      $display("errors %0d checks %0d", err_count, n_checks);
      if (err_count == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : complete_run
   // Release shutdown and time the restart
   task boot;
      sd <= 1;
      t = 0;
      while (en !== 1'b1 && t < 60)
      begin
         @(negedge clk);
         t++;
      end
      chk("restart delay", 1'b1, t > RESTART && t < RESTART + 10);
   endtask : boot
   // Sized for two restarts plus the random run
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         err_count++;
         complete_run();
      end
   end
   initial
   begin
      repeat (10) @(posedge clk);
      nrst <= 1;
      go <= 1;
      boot();
      repeat (2) @(negedge clk);
      chk("wake line", 1'b0, woe);
      chk("wake pin", 1'b0, woe ? 1'b1 : wo);
      chk("power-on evt", 1'b1, st[1]);
      chk("irq line", 1'b0, irq);
      svc = 1;
      repeat (9) @(negedge clk);
      chk("irq cleared", 1'b1, irq);
      chk("read clears", 1'b0, |st);
      svc = 0;
      @(posedge clk);
      msk <= 4'hf;
      ext <= 1;
      @(posedge clk);
      ext <= 0;
      repeat (2) @(negedge clk);
      chk("ext latched", 1'b1, st[3]);
      chk("masked irq", 1'b1, irq);
      @(posedge clk);
      btn <= 0;
      repeat (2) @(posedge clk);
      btn <= 1;
      repeat (6) @(negedge clk);
      chk("button evt", 1'b1, st[0]);
      svc = 1;
      repeat (300)
      begin
         @(posedge clk);
         rs = xs(rs);
         ex <= &rok;
         el <= rok[3] & rok[4];
         rok <= rs[6:0] | {7{rs[7]}};
         ext <= rs[8] & rs[9] & rs[10];
         msk <= rs[14:11];
         btn <= rs[15] | rs[16];
         @(negedge clk);
         chk("all good", ex, ag);
         chk("linear good", el, lg);
      end
      @(posedge clk);
      sd <= 0;
      repeat (9) @(negedge clk);
      chk("shut rails", 1'b0, en);
      chk("shut wake", 1'b1, woe);
      chk("shut irq", 1'b1, irq);
      chk("shut good", 1'b0, ag | lg);
      @(posedge clk);
      boot();
      complete_run();
   end
endmodule : pmic_reset_status_pins_test
`default_nettype wire

// >>> prsp_host_model.sv
// Host model that services the interrupt line
`timescale 1ns/100ps
`default_nettype none
module prsp_host_model (
   // Clock and reset
   input  wire logic clk,
   input  wire logic nrst,
   // Bench control
   input  wire logic service_en,
   input  wire logic start,
   // Pins
   input  wire logic irq_line,
   output logic      evt_read,
   output logic      power_up_request
);
   logic [1:0] wait_q;
   always_ff @(posedge clk or negedge nrst)
   if (!nrst)
   begin
      wait_q           <= 2'h0;
      evt_read         <= 1'b0;
      power_up_request <= 1'b0;
   end
   else
   begin
      power_up_request <= start;
      wait_q           <= (!irq_line && service_en && !evt_read) ? wait_q + 2'h1 : 2'h0;
      evt_read         <= (wait_q == 2'h3);
   end
endmodule : prsp_host_model
`default_nettype wire

// >>> prsp_map.svh
// Constants for the reset and status pin supervisor
`ifndef PRSP_MAP_SVH
`define PRSP_MAP_SVH
`define PRSP_CLK_HZ        250000000
`define PRSP_RESTART_MS    1000
`define PRSP_RESTART_CYC   ((`PRSP_CLK_HZ / 1000) * `PRSP_RESTART_MS)
`define PRSP_NUM_EVT       4
`define PRSP_EVT_BUTTON    0
`define PRSP_EVT_POWER_ON  1
`define PRSP_EVT_RAILS     2
`define PRSP_EVT_EXT       3
`define PRSP_MASK_RESET    4'h0
`define PRSP_NUM_RAILS     7
`define PRSP_RAIL_LIN_ONE  3
`define PRSP_RAIL_LIN_TWO  4
`endif

// >>> prsp_pkg.sv
// Types for the reset and status pin supervisor
package prsp_pkg;
   typedef enum logic [1:0] {
      PRSP_OFF,
      PRSP_WAIT,
      PRSP_IDLE,
      PRSP_ON
   } prsp_state_e;
endpackage : prsp_pkg

// >>> prsp_top.sv
// Reset, interrupt and power-good pin logic
`timescale 1ns/100ps
`include "prsp_map.svh"
`default_nettype none
module prsp_top #(
   parameter int unsigned RESTART_CYC = `PRSP_RESTART_CYC,
   parameter int unsigned NUM_RAILS   = `PRSP_NUM_RAILS
) (
   // Clock and reset
   input  wire logic                      clk,
   input  wire logic                      nrst,
   input  wire logic                      clk_en,
   // Pins from outside
   input  wire logic                      hard_shutdown_input,
   input  wire logic                      button_monitor_input,
   input  wire logic                      power_up_request,
   // Rail status from the regulators, high means in regulation
   input  wire logic [NUM_RAILS-1:0]      rail_ok,
   // External event source, same clock
   input  wire logic                      ext_event,
   // Host-side event bank access, same clock
   input  wire logic [`PRSP_NUM_EVT-1:0]  evt_mask,
   input  wire logic                      evt_read,
   output logic      [`PRSP_NUM_EVT-1:0]  evt_status,
   // Open-drain pins, enable low while pulling low
   output logic                           irq_request_low_o,
   output logic                           irq_request_low_oe_n,
   output logic                           wake_notify_low_o,
   output logic                           wake_notify_low_oe_n,
   // Push-pull pins
   output logic                           all_rails_good,
   output logic                           linear_rails_good,
   output logic                           rails_enable
);
   localparam int unsigned CW = $clog2(RESTART_CYC + 1);
   localparam logic [CW-1:0] CNT_LAST = CW'(RESTART_CYC - 1);

   logic [2:0] rst_sync_q;
   logic [2:0] btn_sync_q;
   logic [2:0] pwr_sync_q;
   logic       rst_pin_q;
   logic       btn_pin_q;
   logic       pwr_pin_q;
   logic       btn_prev_q;
   logic [CW-1:0] cnt_q;
   prsp_pkg::prsp_state_e state_q;
   logic [`PRSP_NUM_EVT-1:0] evt_q;
   logic [`PRSP_NUM_EVT-1:0] evt_set;
   logic all_good_q;
   logic lin_good_q;
   logic wake_q;
   logic active;

   function automatic logic agree(input logic [2:0] s, input logic cur);
      return (s[1] == s[2]) ? s[2] : cur;
   endfunction : agree

   // Three-stage sampling; a level counts once the two later stages agree
   // Stages reset to shutdown held and button released, so no false press follows
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rst_sync_q <= 3'h0;
         btn_sync_q <= 3'h7;
         pwr_sync_q <= 3'h0;
         rst_pin_q  <= 1'b0;
         btn_pin_q  <= 1'b1;
         pwr_pin_q  <= 1'b0;
      end
      else if (clk_en)
      begin
         rst_sync_q <= {rst_sync_q[1:0], hard_shutdown_input};
         btn_sync_q <= {btn_sync_q[1:0], button_monitor_input};
         pwr_sync_q <= {pwr_sync_q[1:0], power_up_request};
         rst_pin_q  <= agree(rst_sync_q, rst_pin_q);
         btn_pin_q  <= agree(btn_sync_q, btn_pin_q);
         pwr_pin_q  <= agree(pwr_sync_q, pwr_pin_q);
      end
   end

   // shutdown and restart delay
   // A shutdown level seen in two samples in a row restarts the wait from zero, so a bouncing pin cannot shorten it
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_q <= prsp_pkg::PRSP_OFF;
         cnt_q   <= '0;
      end
      else if (clk_en)
      begin
         if (!rst_pin_q)
         begin
            state_q <= prsp_pkg::PRSP_OFF;
            cnt_q   <= '0;
         end
         else
         begin
            case (state_q)
               prsp_pkg::PRSP_OFF:
               begin
                  state_q <= prsp_pkg::PRSP_WAIT;
                  cnt_q   <= '0;
               end
               prsp_pkg::PRSP_WAIT:
               begin
                  if (cnt_q == CNT_LAST)
                     state_q <= prsp_pkg::PRSP_IDLE;
                  else
                     cnt_q <= cnt_q + CW'(1);
               end
               // rails start on the power-up request
               prsp_pkg::PRSP_IDLE:
               begin
                  if (pwr_pin_q)
                     state_q <= prsp_pkg::PRSP_ON;
               end
               prsp_pkg::PRSP_ON:
               begin
                  if (!pwr_pin_q)
                     state_q <= prsp_pkg::PRSP_IDLE;
               end
               default:
                  state_q <= prsp_pkg::PRSP_OFF;
            endcase
         end
      end
   end

   assign active = (state_q == prsp_pkg::PRSP_ON);

   // Button edge tracking
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         btn_prev_q <= 1'b1;
      else if (clk_en)
         btn_prev_q <= btn_pin_q;
   end

   // button press is a falling edge on the monitor input
   always_comb
   begin
      evt_set = '0;
      evt_set[`PRSP_EVT_BUTTON]   = btn_prev_q & ~btn_pin_q;
      evt_set[`PRSP_EVT_POWER_ON] = active & ~wake_q;
      evt_set[`PRSP_EVT_RAILS]    = active & all_good_q & ~(&rail_ok);
      evt_set[`PRSP_EVT_EXT]      = ext_event;
   end

   // sticky events; read clears, a new set wins over the read
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         evt_q <= '0;
      else if (clk_en)
      begin
         if (state_q == prsp_pkg::PRSP_OFF)
            evt_q <= '0;
         else if (evt_read)
            evt_q <= evt_set;
         else
            evt_q <= evt_q | evt_set;
      end
   end

   // any rail down, low while off
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         all_good_q <= 1'b0;
      else if (clk_en)
         all_good_q <= active & (&rail_ok);
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         lin_good_q <= 1'b0;
      else if (clk_en)
         lin_good_q <= active & rail_ok[`PRSP_RAIL_LIN_ONE] & rail_ok[`PRSP_RAIL_LIN_TWO];
   end

   // wake notification held low while powered on
   // Registered so the pin cannot glitch while the state decodes
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         wake_q <= 1'b0;
      else if (clk_en)
         wake_q <= active;
   end

   assign evt_status           = evt_q;
   // Open-drain pads only drive low; the enable carries the level
   // unmasked events pull
   assign irq_request_low_o    = 1'b0;
   assign irq_request_low_oe_n = ~(|(evt_q & ~evt_mask));
   assign wake_notify_low_o    = 1'b0;
   assign wake_notify_low_oe_n = ~wake_q;
   assign all_rails_good       = all_good_q;
   assign linear_rails_good    = lin_good_q;
   assign rails_enable         = active;
endmodule : prsp_top
`default_nettype wire

// >>> prsp_top_sva.sv
// Port assertions for the pin supervisor
`timescale 1ns/100ps
`default_nettype none
module prsp_top_sva #(
   parameter int unsigned NUM_RAILS = 7
) (
   // Clock and reset
   input wire logic                 clk,
   input wire logic                 nrst,
   // Watched ports
   input wire logic                 hard_shutdown_input,
   input wire logic                 ext_event,
   input wire logic [NUM_RAILS-1:0] rail_ok,
   input wire logic [3:0]           evt_mask,
   input wire logic                 evt_read,
   input wire logic [3:0]           evt_status,
   input wire logic                 irq_request_low_oe_n,
   input wire logic                 wake_notify_low_oe_n,
   input wire logic                 all_rails_good,
   input wire logic                 linear_rails_good,
   input wire logic                 rails_enable
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   a_irq_pull: assert property (rails_enable && ext_event |=>
      !irq_request_low_oe_n || evt_mask[3]) else $error("irq line not pulled");
   a_irq_masked: assert property (&evt_mask |-> irq_request_low_oe_n)
      else $error("masked event pulls irq");
   // Mask edits may legally release the line, so only stable masks count
   a_irq_release: assert property ($rose(irq_request_low_oe_n) && $stable(evt_mask)
      && rails_enable |-> $past(evt_read)) else $error("irq released without read");
   a_evt_hold: assert property (rails_enable && !evt_read |=> !rails_enable
      || (evt_status & $past(evt_status)) == $past(evt_status)) else $error("event lost");
   a_shut_off: assert property (!hard_shutdown_input [*8] |-> !rails_enable
      && wake_notify_low_oe_n && irq_request_low_oe_n && !all_rails_good
      && !linear_rails_good) else $error("outputs not shut");
   a_all_good: assert property (rails_enable ##1 rails_enable |->
      all_rails_good == $past(&rail_ok)) else $error("all good wrong");
   a_lin_good: assert property (rails_enable ##1 rails_enable |->
      linear_rails_good == $past(rail_ok[3] && rail_ok[4])) else $error("linear good wrong");
   a_wake_on: assert property (rails_enable ##1 rails_enable |->
      !wake_notify_low_oe_n) else $error("wake not pulled");
endmodule : prsp_top_sva
bind prsp_top prsp_top_sva #(.NUM_RAILS(NUM_RAILS)) u_sva (.clk(clk), .nrst(nrst),
   .hard_shutdown_input(hard_shutdown_input), .rail_ok(rail_ok), .evt_mask(evt_mask),
   .evt_read(evt_read), .evt_status(evt_status), .rails_enable(rails_enable),
   .irq_request_low_oe_n(irq_request_low_oe_n), .wake_notify_low_oe_n(wake_notify_low_oe_n),
   .all_rails_good(all_rails_good), .linear_rails_good(linear_rails_good),
   .ext_event(ext_event));
`default_nettype wire
